// ---- verilog/cfpm_pkg.sv ----
package cfpm_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] CFPM_FLAGS_ADDR  = 8'hF7;
  localparam logic [7:0] CFPM_FLAGS_RESET = 8'h00;
  localparam logic [7:0] CFPM_IMPL_MASK   = 8'hF7;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CFPM_GIE_BIT   = 0;
  localparam int CFPM_ZERO_BIT  = 1;
  localparam int CFPM_CARRY_BIT = 2;
  localparam int CFPM_RSVD_BIT  = 3;
  localparam int CFPM_XSEL_BIT  = 4;
  localparam int CFPM_SPARE_BIT = 5;
  localparam int CFPM_PAGE_LSB  = 6;

  // ==========================================================================
  // Paging modes and flag operations
  // ==========================================================================
  typedef enum logic [1:0]
  {
    CFPM_PG_ZERO     = 2'b00,
    CFPM_PG_IDX_STK  = 2'b01,
    CFPM_PG_CUR_IDX  = 2'b10,
    CFPM_PG_CUR_STK  = 2'b11
  } cfpm_page_mode_type;

  typedef enum logic [1:0]
  {
    CFPM_OP_NONE = 2'b00,
    CFPM_OP_AND  = 2'b01,
    CFPM_OP_OR   = 2'b10,
    CFPM_OP_XOR  = 2'b11
  } cfpm_flag_op_type;

  localparam logic [7:0] CFPM_PAGE_ZERO = 8'h00;

endpackage

// ---- verilog/cfpm_flags.sv ----
// Functional notes
// - Mode 00 sends all operands to page 0.
// - Interrupt entry clears the whole flag register.
// - Mode 01: direct page 0, indexed stack page.
// - Mode 10: direct current page, indexed index page.
// - Mode 11: direct current page, indexed stack page.
// - Bit 4 selects extended register space.
// - Carry bit 2 follows each ALU operation unless a flag instruction or interrupt entry shares its cycle.
// - Zero bit 1 follows each ALU operation unless a flag instruction or interrupt entry shares its cycle.
// - Bit 0 zero blocks IRQ_TAKE; interrupt entry still clears the register.
// - Readable; changed by AND/OR/XOR immediate, by ALU update (bits 1 and 2) and by interrupt entry.
// - Bit 5 stores a value, drives nothing.
`timescale 1ns/1ps
module cfpm_flags
  import cfpm_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RESET_N,
  input  wire logic       IRQ_ENTRY,
  input  wire logic [1:0] FLAG_OP,
  input  wire logic [7:0] FLAG_IMM,
  input  wire logic       ALU_UPDATE,
  input  wire logic       ALU_CARRY,
  input  wire logic [7:0] ALU_RESULT,
  input  wire logic       IRQ_REQUEST,
  input  wire logic       DIRECT_ACCESS,
  input  wire logic [7:0] CURRENT_PAGE_POINTER,
  input  wire logic [7:0] INDEX_PAGE_POINTER,
  input  wire logic [7:0] STACK_PAGE_POINTER,
  input  wire logic [7:0] REG_ADDR,
  output logic      [7:0] REG_RDATA,
  output logic            REG_HIT,
  output logic      [7:0] OPERAND_PAGE,
  output logic            EXTENDED_SPACE_SELECT,
  output logic            IRQ_TAKE
);

  // ==========================================================================
  // Flag register
  // ==========================================================================
  logic [7:0]         flags_reg;
  logic [7:0]         flags_next;
  cfpm_page_mode_type ram_paging_select;
  logic               global_irq_enable;
  logic               spare_unconnected_bit;

  function automatic logic [7:0] cfpm_apply_op(input logic [7:0] cur,
                                               input cfpm_flag_op_type op,
                                               input logic [7:0] imm);
    logic [7:0] res;
    res = cur;
    case (op)
      CFPM_OP_AND: res = cur & imm;
      CFPM_OP_OR:  res = cur | imm;
      CFPM_OP_XOR: res = cur ^ imm;
      default:     res = cur;
    endcase
    return res & CFPM_IMPL_MASK;
  endfunction

  always_comb
  begin
    flags_next = flags_reg;
    if (IRQ_ENTRY)
    begin
      flags_next = CFPM_FLAGS_RESET;
    end
    else if (cfpm_flag_op_type'(FLAG_OP) != CFPM_OP_NONE)
    begin
      flags_next = cfpm_apply_op(flags_reg, cfpm_flag_op_type'(FLAG_OP), FLAG_IMM);
    end
    else if (ALU_UPDATE)
    begin
      flags_next[CFPM_CARRY_BIT] = ALU_CARRY;
      flags_next[CFPM_ZERO_BIT] = (ALU_RESULT == 8'h00);
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      flags_reg <= CFPM_FLAGS_RESET;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  assign ram_paging_select     = cfpm_page_mode_type'(flags_reg[CFPM_PAGE_LSB +: 2]);
  assign global_irq_enable     = flags_reg[CFPM_GIE_BIT];
  assign spare_unconnected_bit = flags_reg[CFPM_SPARE_BIT];

  // ==========================================================================
  // Register read port
  // ==========================================================================
  always_comb
  begin
    REG_HIT   = (REG_ADDR == CFPM_FLAGS_ADDR);
    REG_RDATA = REG_HIT ? flags_reg : 8'h00;
  end

  // ==========================================================================
  // Operand paging
  // ==========================================================================
  always_comb
  begin
    OPERAND_PAGE = CFPM_PAGE_ZERO;
    case (ram_paging_select)
      CFPM_PG_ZERO:    OPERAND_PAGE = CFPM_PAGE_ZERO;
      CFPM_PG_IDX_STK: OPERAND_PAGE = DIRECT_ACCESS ? CFPM_PAGE_ZERO : STACK_PAGE_POINTER;
      CFPM_PG_CUR_IDX: OPERAND_PAGE = DIRECT_ACCESS ? CURRENT_PAGE_POINTER
                                                    : INDEX_PAGE_POINTER;
      CFPM_PG_CUR_STK: OPERAND_PAGE = DIRECT_ACCESS ? CURRENT_PAGE_POINTER
                                                    : STACK_PAGE_POINTER;
      default:         OPERAND_PAGE = CFPM_PAGE_ZERO;
    endcase
  end

  assign EXTENDED_SPACE_SELECT = flags_reg[CFPM_XSEL_BIT];
  assign IRQ_TAKE = IRQ_REQUEST & global_irq_enable;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_entry;
    IRQ_ENTRY;
  endsequence

  chk_entry_clears: assert property (@(posedge MCLK) disable iff (!RESET_N)
    s_entry |=> (flags_reg == 8'h00) && (OPERAND_PAGE == 8'h00) && !IRQ_TAKE)
    else $error("flags not cleared after interrupt entry");

  chk_mode_zero: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (flags_reg[7:6] == 2'b00) |-> (OPERAND_PAGE == 8'h00))
    else $error("mode 00 did not select page 0");

  chk_mode_one: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (flags_reg[7:6] == 2'b01) |->
      (OPERAND_PAGE == (DIRECT_ACCESS ? 8'h00 : STACK_PAGE_POINTER)))
    else $error("mode 01 page wrong");

  chk_mode_two: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (flags_reg[7:6] == 2'b10) |->
      (OPERAND_PAGE == (DIRECT_ACCESS ? CURRENT_PAGE_POINTER : INDEX_PAGE_POINTER)))
    else $error("mode 10 page wrong");

  chk_mode_three: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (flags_reg[7:6] == 2'b11) |->
      (OPERAND_PAGE == (DIRECT_ACCESS ? CURRENT_PAGE_POINTER : STACK_PAGE_POINTER)))
    else $error("mode 11 page wrong");

  chk_space_sel: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (FLAG_OP == 2'b10) && FLAG_IMM[4] && !IRQ_ENTRY |=> EXTENDED_SPACE_SELECT)
    else $error("space select not set by OR");

  chk_carry_upd: assert property (@(posedge MCLK) disable iff (!RESET_N)
    ALU_UPDATE && (FLAG_OP == 2'b00) && !IRQ_ENTRY |=> (flags_reg[2] == $past(ALU_CARRY)))
    else $error("carry flag not updated");

  chk_zero_upd: assert property (@(posedge MCLK) disable iff (!RESET_N)
    ALU_UPDATE && (FLAG_OP == 2'b00) && !IRQ_ENTRY |=>
      (flags_reg[1] == ($past(ALU_RESULT) == 8'h00)))
    else $error("zero flag not updated");

  chk_irq_gate: assert property (@(posedge MCLK) disable iff (!RESET_N)
    IRQ_TAKE |-> IRQ_REQUEST && flags_reg[0])
    else $error("interrupt taken while disabled");

  chk_only_ops: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !IRQ_ENTRY && (FLAG_OP == 2'b00) && !ALU_UPDATE |=> $stable(flags_reg))
    else $error("flags changed without an instruction");

  chk_xor_apply: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !IRQ_ENTRY && (FLAG_OP == 2'b11) |=>
      (flags_reg == (($past(flags_reg) ^ $past(FLAG_IMM)) & 8'hF7)))
    else $error("xor flag update wrong");

  chk_rsvd_zero: assert property (@(posedge MCLK) disable iff (!RESET_N)
    flags_reg[3] == 1'b0)
    else $error("reserved bit set");

  chk_spare_kept: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !IRQ_ENTRY && (FLAG_OP == 2'b10) && FLAG_IMM[5] |=> spare_unconnected_bit)
    else $error("spare bit not stored");

  chk_reset_val: assert property (@(posedge MCLK)
    $rose(RESET_N) |-> (flags_reg == 8'h00))
    else $error("flags not zero after reset");

  // ==========================================================================
  // Instruction and priority checks
  // ==========================================================================
  sequence s_and_op;
    !IRQ_ENTRY && (FLAG_OP == 2'b01);
  endsequence

  sequence s_or_op;
    !IRQ_ENTRY && (FLAG_OP == 2'b10);
  endsequence

  sequence s_alu_only;
    !IRQ_ENTRY && (FLAG_OP == 2'b00) && ALU_UPDATE;
  endsequence

  sequence s_idle;
    !IRQ_ENTRY && (FLAG_OP == 2'b00) && !ALU_UPDATE;
  endsequence

  chk_and_apply: assert property (@(posedge MCLK) disable iff (!RESET_N)
    s_and_op |=>
      (flags_reg == ($past(flags_reg) & $past(FLAG_IMM) & 8'hF7)))
    else $error("and flag update wrong");

  chk_or_apply: assert property (@(posedge MCLK) disable iff (!RESET_N)
    s_or_op |=>
      (flags_reg == (($past(flags_reg) | $past(FLAG_IMM)) & 8'hF7)))
    else $error("or flag update wrong");

  chk_alu_upper: assert property (@(posedge MCLK) disable iff (!RESET_N)
    s_alu_only |=> (flags_reg[7:3] == $past(flags_reg[7:3])))
    else $error("alu update touched upper flags");

  chk_alu_gie: assert property (@(posedge MCLK) disable iff (!RESET_N)
    s_alu_only |=> (flags_reg[0] == $past(flags_reg[0])))
    else $error("alu update touched interrupt enable");

  chk_carry_hold: assert property (@(posedge MCLK) disable iff (!RESET_N)
    s_idle |=> (flags_reg[2] == $past(flags_reg[2])))
    else $error("carry changed without an operation");

  chk_irq_prio: assert property (@(posedge MCLK) disable iff (!RESET_N)
    IRQ_ENTRY && (FLAG_OP != 2'b00) |=> (flags_reg == 8'h00))
    else $error("flag instruction beat interrupt entry");

  // An instruction right after entry starts again from a cleared register.
  chk_or_after_entry: assert property (@(posedge MCLK) disable iff (!RESET_N)
    s_entry ##1 s_or_op |=> (flags_reg == ($past(FLAG_IMM) & 8'hF7)))
    else $error("or after entry did not start from zero");

  chk_mode_entry: assert property (@(posedge MCLK) disable iff (!RESET_N)
    s_entry |=> (flags_reg[7:6] == 2'b00))
    else $error("paging mode kept over interrupt entry");

  chk_entry_xsel: assert property (@(posedge MCLK) disable iff (!RESET_N)
    s_entry |=> !EXTENDED_SPACE_SELECT)
    else $error("space select kept over interrupt entry");

  chk_xsel_follow: assert property (@(posedge MCLK) disable iff (!RESET_N)
    EXTENDED_SPACE_SELECT == flags_reg[4])
    else $error("space select differs from flag");

  chk_gate_open: assert property (@(posedge MCLK) disable iff (!RESET_N)
    IRQ_REQUEST && flags_reg[0] |-> IRQ_TAKE)
    else $error("enabled interrupt not taken");

  chk_gate_shut: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !flags_reg[0] |-> !IRQ_TAKE)
    else $error("interrupt passed a cleared enable");

  chk_hit_decode: assert property (@(posedge MCLK) disable iff (!RESET_N)
    REG_HIT == (REG_ADDR == 8'hF7))
    else $error("register address decode wrong");

  chk_rdata_hit: assert property (@(posedge MCLK) disable iff (!RESET_N)
    REG_HIT |-> (REG_RDATA == flags_reg))
    else $error("read data differs from flags");

  chk_rdata_miss: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !REG_HIT |-> (REG_RDATA == 8'h00))
    else $error("read data not zero on a miss");

  chk_spare_clear: assert property (@(posedge MCLK) disable iff (!RESET_N)
    s_and_op ##0 !FLAG_IMM[5] |=> !spare_unconnected_bit)
    else $error("spare bit not cleared");

endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import cfpm_pkg::*;
  logic       mclk, reset_n, irq_entry, alu_update, alu_carry, irq_req, direct;
  logic [1:0] flag_op;
  logic [7:0] imm, alu_res, current_page_pointer, index_page_pointer, stack_page_pointer, reg_addr, exp_f, rdata, page;
  logic       hit, ext_sel, irq_take;
  int         error_cnt, n_tests;
  logic [7:0] dir_t [4] = '{8'h00, 8'h00, 8'h11, 8'h11};
  logic [7:0] idx_t [4] = '{8'h00, 8'h33, 8'h22, 8'h33};

  cfpm_flags u_dut (.MCLK(mclk), .RESET_N(reset_n), .IRQ_ENTRY(irq_entry), .FLAG_OP(flag_op),
    .FLAG_IMM(imm), .ALU_UPDATE(alu_update), .ALU_CARRY(alu_carry), .ALU_RESULT(alu_res),
    .IRQ_REQUEST(irq_req), .DIRECT_ACCESS(direct), .CURRENT_PAGE_POINTER(current_page_pointer),
    .INDEX_PAGE_POINTER(index_page_pointer), .STACK_PAGE_POINTER(stack_page_pointer), .REG_ADDR(reg_addr),
    .REG_RDATA(rdata), .REG_HIT(hit), .OPERAND_PAGE(page),
    .EXTENDED_SPACE_SELECT(ext_sel), .IRQ_TAKE(irq_take));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Requests are presented for one edge, then withdrawn.
  task automatic drive(input logic [1:0] op, input logic [7:0] v, input logic irq,
                       input logic alu, input logic cy, input logic [7:0] res);
    @(posedge mclk);
    flag_op <= op;
    imm <= v;
    irq_entry <= irq;
    alu_update <= alu;
    alu_carry <= cy;
    alu_res <= res;
    @(posedge mclk);
    flag_op <= 2'h0;
    irq_entry <= 1'b0;
    alu_update <= 1'b0;
    #1;
  endtask

  task automatic fop(input logic [1:0] op, input logic [7:0] v);
    drive(op, v, 1'b0, 1'b0, 1'b0, 8'h00);
    case (op)
      2'h1: exp_f = exp_f & v;
      2'h2: exp_f = exp_f | v;
      2'h3: exp_f = exp_f ^ v;
      default: exp_f = exp_f;
    endcase
    exp_f = exp_f & CFPM_IMPL_MASK;
    chk(rdata, exp_f);
  endtask

  task automatic sel_dir(input logic d);
    @(posedge mclk);
    direct <= d;
    #1;
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset;
    chk(rdata, 8'h00);
    chk({page, 5'h00, hit, ext_sel, irq_take}, 16'h0004);
    $display("t_reset done");
  endtask

  task automatic t_pages;
    for (int m = 0; m < 4; m++)
    begin
      fop(2'h1, 8'h00);
      fop(2'h2, {m[1:0], 6'h00});
      sel_dir(1'b1);
      chk(page, dir_t[m]);
      sel_dir(1'b0);
      chk(page, idx_t[m]);
    end
    $display("t_pages done");
  endtask

  task automatic t_bits;
    fop(2'h2, 8'hFF);
    chk({6'h00, ext_sel, irq_take}, 8'h03);
    fop(2'h3, 8'h10);
    chk({7'h00, ext_sel}, 8'h00);
    fop(2'h1, 8'h20);
    chk({7'h00, irq_take}, 8'h00);
    @(posedge mclk);
    reg_addr <= 8'hF6;
    #1;
    chk({rdata, 7'h00, hit}, 16'h0000);
    @(posedge mclk);
    reg_addr <= CFPM_FLAGS_ADDR;
    $display("t_bits done");
  endtask

  task automatic t_alu;
    drive(2'h0, 8'h00, 1'b0, 1'b1, 1'b1, 8'h00);
    exp_f = exp_f | 8'h06;
    chk(rdata, exp_f);
    drive(2'h0, 8'h00, 1'b0, 1'b1, 1'b0, 8'h05);
    exp_f = exp_f & 8'hF9;
    chk(rdata, exp_f);
    drive(2'h2, 8'h01, 1'b0, 1'b1, 1'b1, 8'h00);
    exp_f = exp_f | 8'h01;
    chk(rdata, exp_f);
    $display("t_alu done");
  endtask

  task automatic t_irq;
    fop(2'h2, 8'hFF);
    drive(2'h2, 8'hFF, 1'b1, 1'b1, 1'b1, 8'h00);
    chk({rdata, page}, 16'h0000);
    $display("t_irq done");
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial
  begin
    {reset_n, irq_entry, alu_update, alu_carry, direct, flag_op, imm, alu_res} = '0;
    {current_page_pointer, index_page_pointer, stack_page_pointer, reg_addr, irq_req} = {8'h11, 8'h22, 8'h33, 8'hF7, 1'b1};
    exp_f = 8'h00;
    error_cnt = 0;
    n_tests = 0;
    repeat (6) @(posedge mclk);
    #1;
    t_reset();
    reset_n <= 1'b1;
    t_pages();
    t_bits();
    t_alu();
    t_irq();
    report_and_stop();
  end

  initial
  begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
endmodule
